// File: swl_dev.sv
// sensor end of the single-wire bit link
//
// Notes on behaviour
// - one answer bit for each master bit
// - bit rate learnt from first bit
// - link always offered during start-up
// - both ends only pull low, open drain
// - bits grouped into counted 16-bit words
// - command word bits echoed back
// - safety word closes every sequence
// - quiet line past reset time restarts link
// - master bit: period T, then short pulse
// - zero: master low 0.2T to 0.33T
// - one: master low 0.66T to 0.8T
// - period is fall to next fall
// - period between 2 us and 980 us
// - answer one: pull low for delta-T
// - master samples before delta-T ends
// - master pause at most 810 us
// - master waits 1 us between words
// - zeros clock out read and safety words
// - words travel msb first
`timescale 1ns/10ps
`default_nettype none
module swl_dev
   import swl_pkg::*;
#(
   parameter int unsigned TRES_CYC = TRES_CYC_DEF
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // one-wire link
   swl_if.dev LINK,
   // link enable
   input wire logic STARTUP,
   input wire logic LINK_CFG_EN,
   // words from the sensor core
   input wire logic [WORD_W-1:0] RD_WORD,
   input wire logic [WORD_W-1:0] SAFETY_WORD,
   // words to the sensor core
   output logic [WORD_W-1:0] CMD_WORD,
   output logic CMD_STB,
   output logic [WORD_W-1:0] WR_WORD,
   output logic WR_STB,
   // link status
   output logic [CNT_W-1:0] LINK_PERIOD,
   output logic LINK_TIMEOUT
);
   localparam logic [CNT_W-1:0] TRES_LIM = CNT_W'(TRES_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;

   typedef enum logic [2:0] {
      ST_WAIT = 3'b000,
      ST_LOW = 3'b001,
      ST_HIGH = 3'b010,
      ST_DRIVE = 3'b011,
      ST_REL = 3'b100
   } swl_dstate_e;

   swl_dstate_e state_q;
   swl_phase_e phase_q;
   logic line_m_q, line_s_q, line_d_q;
   logic [CNT_W-1:0] low_q, high_q, dt_q, quiet_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [LEN_W-1:0] words_left_q;
   logic read_q;
   logic [WORD_W-1:0] rx_sh_q, tx_sh_q;
   logic oe_n_q;
   logic link_on, fall, rise, rx_bit, bit_done, word_start, in_xfer, timeout;
   logic echo, resp_bit;
   logic [CNT_W-1:0] dt;
   logic [WORD_W-1:0] new_word;

   ////////////////////////////////////////////////////////////////////////
   // line sampling and bit decode

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         line_m_q <= 1'b1;
         line_s_q <= 1'b1;
         line_d_q <= 1'b1;
      end else begin
         line_m_q <= LINK.line_lvl;
         line_s_q <= line_m_q;
         line_d_q <= line_s_q;
      end
   end

   // start-up keeps the link alive whatever the output setting
   assign link_on = STARTUP | LINK_CFG_EN;
   assign fall = line_d_q & ~line_s_q;
   assign rise = ~line_d_q & line_s_q;
   // ratio decode needs no trimmed clock, only the two counts
   assign rx_bit = low_q > high_q;
   assign dt = rx_bit ? low_q - high_q : high_q - low_q;
   assign bit_done = (state_q == ST_HIGH) && fall;
   assign word_start = (state_q == ST_WAIT) && fall && (bit_cnt_q == '0);
   assign in_xfer = !((phase_q == PH_CMD) && (bit_cnt_q == '0));
   assign timeout = in_xfer && (quiet_q >= TRES_LIM);
   assign echo = (phase_q == PH_CMD) || ((phase_q == PH_DATA) && !read_q);
   assign resp_bit = echo ? rx_bit : tx_sh_q[WORD_W-1];
   assign new_word = {rx_sh_q[WORD_W-2:0], rx_bit};

   ////////////////////////////////////////////////////////////////////////
   // bit timing and open-drain answer

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ST_WAIT;
         low_q <= '0;
         high_q <= '0;
         dt_q <= '0;
         oe_n_q <= 1'b1;
      end else if (!link_on || timeout) begin
         state_q <= ST_WAIT;
         oe_n_q <= 1'b1;
      end else begin
         unique case (state_q)
            ST_WAIT: begin
               if (fall) begin
                  state_q <= ST_LOW;
                  low_q <= CNT_ONE;
               end
            end
            ST_LOW: begin
               if (rise) begin
                  state_q <= ST_HIGH;
                  high_q <= CNT_ONE;
               end else begin
                  low_q <= low_q + CNT_ONE;
               end
            end
            ST_HIGH: begin
               if (fall) begin
                  // one answer per bit, overlapping the trailing pulse
                  if (resp_bit) begin
                     state_q <= ST_DRIVE;
                     dt_q <= dt;
                     oe_n_q <= 1'b0;
                  end else begin
                     state_q <= ST_REL;
                  end
               end else begin
                  high_q <= high_q + CNT_ONE;
               end
            end
            ST_DRIVE: begin
               if (dt_q <= CNT_ONE) begin
                  state_q <= ST_REL;
                  oe_n_q <= 1'b1;
               end else begin
                  dt_q <= dt_q - CNT_ONE;
               end
            end
            ST_REL: begin
               // wait out the master pulse before looking for the next bit
               if (line_s_q) begin
                  state_q <= ST_WAIT;
               end
            end
         endcase
      end
   end

   assign LINK.dev_out = 1'b0;
   assign LINK.dev_oe_n = oe_n_q;

   ////////////////////////////////////////////////////////////////////////
   // interface reset timer, cleared by every line edge

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         quiet_q <= '0;
      end else if (!link_on || fall || rise || !in_xfer) begin
         quiet_q <= '0;
      end else begin
         quiet_q <= quiet_q + CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // word sequencing: command, data words, safety word

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         phase_q <= PH_CMD;
         bit_cnt_q <= '0;
         words_left_q <= '0;
         read_q <= 1'b0;
         rx_sh_q <= '0;
         tx_sh_q <= '0;
         CMD_WORD <= '0;
         CMD_STB <= 1'b0;
         WR_WORD <= '0;
         WR_STB <= 1'b0;
         LINK_PERIOD <= '0;
         LINK_TIMEOUT <= 1'b0;
      end else begin
         CMD_STB <= 1'b0;
         WR_STB <= 1'b0;
         LINK_TIMEOUT <= 1'b0;
         if (!link_on || timeout) begin
            phase_q <= PH_CMD;
            bit_cnt_q <= '0;
            LINK_TIMEOUT <= link_on;
         end else begin
            // core words are taken late so the inter-word gap can refresh them
            if (word_start) begin
               tx_sh_q <= (phase_q == PH_SAFE) ? SAFETY_WORD : RD_WORD;
            end
            if (bit_done) begin
               rx_sh_q <= new_word;
               tx_sh_q <= tx_sh_q << 1;
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if ((phase_q == PH_CMD) && (bit_cnt_q == '0)) begin
                  LINK_PERIOD <= low_q + high_q;
               end
               if (bit_cnt_q == LAST_BIT) begin
                  unique case (phase_q)
                     PH_CMD: begin
                        CMD_WORD <= new_word;
                        CMD_STB <= 1'b1;
                        read_q <= new_word[CMD_RW_BIT];
                        words_left_q <= new_word[CMD_LEN_LSB +: LEN_W];
                        phase_q <= (new_word[CMD_LEN_LSB +: LEN_W] == '0) ? PH_SAFE : PH_DATA;
                     end
                     PH_DATA: begin
                        if (!read_q) begin
                           WR_WORD <= new_word;
                           WR_STB <= 1'b1;
                        end
                        words_left_q <= words_left_q - LEN_ONE;
                        if (words_left_q == LEN_ONE) begin
                           phase_q <= PH_SAFE;
                        end
                     end
                     default: begin
                        phase_q <= PH_CMD;
                     end
                  endcase
               end
            end
         end
      end
   end

endmodule // swl_dev
`default_nettype wire

// File: swl_host.sv
// master end of the single-wire bit link, with a buffer for read words
`timescale 1ns/10ps
`default_nettype none
module swl_host
   import swl_pkg::*;
#(
   // bit timing is open so a bench can run the link at its fastest legal period
   parameter int unsigned T_CYC = T_CYC_DEF,
   parameter int unsigned T1_CYC = ZERO_LOW_CYC,
   parameter int unsigned T2_CYC = ONE_LOW_CYC,
   parameter int unsigned T3_CYC = POST_PULSE_CYC,
   parameter int unsigned SMP_CYC = SAMPLE_CYC,
   parameter int unsigned PAUSE_CYC = PAUSE_CYC_DEF
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // one-wire link
   swl_if.host LINK,
   // request
   input wire logic START,
   input wire logic [WORD_W-1:0] CMD_IN,
   input wire logic [WORD_W-1:0] WR_DATA,
   output logic WR_TAKEN,
   output logic BUSY,
   // read words
   output logic [WORD_W-1:0] RD_DATA,
   output logic RD_VALID,
   input wire logic RD_READY,
   // result
   output logic [WORD_W-1:0] SAFETY_OUT,
   output logic DONE,
   output logic ECHO_ERR
);
   localparam logic [CNT_W-1:0] C_T = CNT_W'(T_CYC);
   localparam logic [CNT_W-1:0] C_T1 = CNT_W'(T1_CYC);
   localparam logic [CNT_W-1:0] C_T2 = CNT_W'(T2_CYC);
   localparam logic [CNT_W-1:0] C_T3 = CNT_W'(T3_CYC);
   localparam logic [CNT_W-1:0] C_SMP = CNT_W'(SMP_CYC);
   localparam logic [CNT_W-1:0] C_T4 = CNT_W'(PAUSE_CYC);
   localparam logic [CNT_W-1:0] C_GAP = CNT_W'(GAP_CYC);
   localparam logic [FPTR_W:0] F_FULL = (FPTR_W + 1)'(FIFO_DEPTH);

   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_LOW = 3'b001,
      HS_HIGH = 3'b010,
      HS_POST = 3'b011,
      HS_RESP = 3'b100,
      HS_PAUSE = 3'b101,
      HS_GAP = 3'b110
   } swl_hstate_e;

   swl_hstate_e state_q;
   swl_phase_e phase_q;
   logic line_m_q, line_s_q, oe_n_q, read_q;
   logic [CNT_W-1:0] cnt_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [LEN_W-1:0] words_left_q;
   logic [WORD_W-1:0] tx_sh_q, sent_q, rx_sh_q;
   logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
   logic [FPTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [FPTR_W:0] fcnt_q;
   logic word_end, push, pop, stall;

   assign word_end = (state_q == HS_PAUSE) && (cnt_q >= C_T4) && (bit_cnt_q == '0);
   assign push = word_end && (phase_q == PH_DATA) && read_q;
   assign pop = RD_VALID && RD_READY;
   // a full buffer holds the next read word back instead of dropping it
   assign stall = (phase_q == PH_DATA) && read_q && (fcnt_q == F_FULL);
   assign RD_VALID = (fcnt_q != '0);
   assign RD_DATA = mem_q[rd_ptr_q];
   assign BUSY = (state_q != HS_IDLE);
   assign LINK.host_out = 1'b0;
   assign LINK.host_oe_n = oe_n_q;

   ////////////////////////////////////////////////////////////////////////
   // line sampling

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         line_m_q <= 1'b1;
         line_s_q <= 1'b1;
      end else begin
         line_m_q <= LINK.line_lvl;
         line_s_q <= line_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit generation and word sequencing

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= HS_IDLE;
         phase_q <= PH_CMD;
         cnt_q <= '0;
         oe_n_q <= 1'b1;
         read_q <= 1'b0;
         bit_cnt_q <= '0;
         words_left_q <= '0;
         tx_sh_q <= '0;
         sent_q <= '0;
         rx_sh_q <= '0;
         WR_TAKEN <= 1'b0;
         SAFETY_OUT <= '0;
         DONE <= 1'b0;
         ECHO_ERR <= 1'b0;
      end else begin
         WR_TAKEN <= 1'b0;
         DONE <= 1'b0;
         cnt_q <= cnt_q + 19'h00001;
         unique case (state_q)
            HS_IDLE: begin
               if (START) begin
                  phase_q <= PH_CMD;
                  ECHO_ERR <= 1'b0;
                  tx_sh_q <= CMD_IN;
                  sent_q <= CMD_IN;
                  state_q <= HS_LOW;
                  oe_n_q <= 1'b0;
                  // counting from one makes each level last exactly its count
                  cnt_q <= 19'h00001;
               end
            end
            HS_LOW: begin
               if (cnt_q >= (tx_sh_q[WORD_W-1] ? C_T2 : C_T1)) begin
                  oe_n_q <= 1'b1;
                  state_q <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               if (cnt_q >= C_T) begin
                  oe_n_q <= 1'b0;
                  state_q <= HS_POST;
                  cnt_q <= 19'h00001;
               end
            end
            HS_POST: begin
               if (cnt_q >= C_T3) begin
                  oe_n_q <= 1'b1;
                  state_q <= HS_RESP;
               end
            end
            HS_RESP: begin
               if (cnt_q >= C_SMP) begin
                  // a low line is the sensor's one
                  rx_sh_q <= {rx_sh_q[WORD_W-2:0], ~line_s_q};
                  tx_sh_q <= tx_sh_q << 1;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  state_q <= HS_PAUSE;
                  cnt_q <= '0;
               end
            end
            HS_PAUSE: begin
               if (cnt_q >= C_T4) begin
                  if (bit_cnt_q != '0) begin
                     oe_n_q <= 1'b0;
                     state_q <= HS_LOW;
                     cnt_q <= 19'h00001;
                  end else begin
                     cnt_q <= '0;
                     state_q <= HS_GAP;
                     unique case (phase_q)
                        PH_CMD: begin
                           ECHO_ERR <= ECHO_ERR | (rx_sh_q != sent_q);
                           read_q <= sent_q[CMD_RW_BIT];
                           words_left_q <= sent_q[CMD_LEN_LSB +: LEN_W];
                           phase_q <= (sent_q[CMD_LEN_LSB +: LEN_W] == '0) ? PH_SAFE : PH_DATA;
                        end
                        PH_DATA: begin
                           if (!read_q) begin
                              ECHO_ERR <= ECHO_ERR | (rx_sh_q != sent_q);
                           end
                           words_left_q <= words_left_q - LEN_ONE;
                           if (words_left_q == LEN_ONE) begin
                              phase_q <= PH_SAFE;
                           end
                        end
                        default: begin
                           SAFETY_OUT <= rx_sh_q;
                           DONE <= 1'b1;
                           phase_q <= PH_CMD;
                           state_q <= HS_IDLE;
                        end
                     endcase
                  end
               end
            end
            HS_GAP: begin
               if ((cnt_q >= C_GAP) && !stall) begin
                  // reads and the safety word are clocked out by zeros
                  if ((phase_q == PH_DATA) && !read_q) begin
                     tx_sh_q <= WR_DATA;
                     sent_q <= WR_DATA;
                     WR_TAKEN <= 1'b1;
                  end else begin
                     tx_sh_q <= '0;
                     sent_q <= '0;
                  end
                  oe_n_q <= 1'b0;
                  state_q <= HS_LOW;
                  cnt_q <= 19'h00001;
               end
            end
            default: begin
               state_q <= HS_IDLE;
               oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry read buffer

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fcnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         fcnt_q <= fcnt_q + {{FPTR_W{1'b0}}, push} - {{FPTR_W{1'b0}}, pop};
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (push) begin
         mem_q[wr_ptr_q] <= rx_sh_q;
      end
   end

endmodule // swl_host
`default_nettype wire

// File: swl_if.sv
// open-drain single wire shared by the sensor end and the master end
`timescale 1ns/10ps
`default_nettype none
interface swl_if;
   logic dev_out;
   logic dev_oe_n;
   logic host_out;
   logic host_oe_n;
   logic line_lvl;
   // pull-up wins unless an enabled driver pulls low
   assign line_lvl = ~((~dev_oe_n & ~dev_out) | (~host_oe_n & ~host_out));
   modport dev (input line_lvl, output dev_out, output dev_oe_n);
   modport host (input line_lvl, output host_out, output host_oe_n);
endinterface
`default_nettype wire

// File: swl_pkg.sv
// shared constants and types of the single-wire bit link
`default_nettype none
package swl_pkg;
   localparam int CLK_NS = 4;
   localparam int WORD_W = 16;
   localparam int BIT_CNT_W = 4;
   localparam int LEN_W = 4;
   localparam int CNT_W = 19;
   localparam int CMD_RW_BIT = 15;
   localparam int CMD_LEN_LSB = 0;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;
   localparam logic [LEN_W-1:0] LEN_ONE = 4'h1;
   // interface reset time, typical figure
   localparam int TRES_US = 820;
   localparam int TRES_CYC_DEF = TRES_US * 1000 / CLK_NS;
   // master bit timing, an example set that fits the start-up window
   localparam int T_NS = 21100;
   localparam int ZERO_LOW_NS = 6600;
   localparam int ONE_LOW_NS = 14500;
   localparam int POST_PULSE_NS = 3500;
   localparam int DT_NS = 7900;
   localparam int SAMPLE_PCT = 80;
   localparam int PAUSE_NS = 25000;
   localparam int GAP_NS = 1000;
   localparam int T_CYC_DEF = (T_NS + CLK_NS - 1) / CLK_NS;
   localparam int ZERO_LOW_CYC = (ZERO_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int ONE_LOW_CYC = (ONE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int POST_PULSE_CYC = (POST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SAMPLE_CYC = DT_NS * SAMPLE_PCT / 100 / CLK_NS;
   localparam int PAUSE_CYC_DEF = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   // read-word buffer of the master end
   localparam int FIFO_DEPTH = 2;
   localparam int FPTR_W = 1;
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_DATA = 2'b01,
      PH_SAFE = 2'b10
   } swl_phase_e;
endpackage
`default_nettype wire

// File: swl_properties.sv
// wire-level checks of the single-wire link, watching both ends
`timescale 1ns/10ps
`default_nettype none
module swl_properties
   import swl_pkg::*;
#(
   parameter int DT_MIN = 1974,
   parameter int DT_MAX = 1976,
   parameter int T1_CYC = ZERO_LOW_CYC,
   parameter int T2_CYC = ONE_LOW_CYC,
   parameter int T3_CYC = POST_PULSE_CYC
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // wire signals
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic host_out,
   input wire logic host_oe_n,
   input wire logic line_lvl
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] dev_cnt_q;
   logic [15:0] host_cnt_q;
   logic dev_q;
   logic host_q;
   logic bit_seen_q;
   // length of the current low drive of each end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) dev_cnt_q <= '0;
      else if (!dev_oe_n) dev_cnt_q <= dev_cnt_q + 16'h0001;
      else dev_cnt_q <= '0;
   end
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) host_cnt_q <= '0;
      else if (!host_oe_n) host_cnt_q <= host_cnt_q + 16'h0001;
      else host_cnt_q <= '0;
   end
   // a master fall must come between two answers, so one answer per bit at most
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dev_q <= 1'h1;
         host_q <= 1'h1;
         bit_seen_q <= 1'h0;
      end else begin
         dev_q <= dev_oe_n;
         host_q <= host_oe_n;
         if (dev_q && !dev_oe_n) bit_seen_q <= 1'h0;
         else if (host_q && !host_oe_n) bit_seen_q <= 1'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_answer_start;
      $fell(dev_oe_n);
   endsequence
   sequence s_answer_end;
      $rose(dev_oe_n);
   endsequence
   property p_dev_pull_only;
      !dev_oe_n |-> !dev_out;
   endproperty
   property p_host_pull_only;
      !host_oe_n |-> !host_out;
   endproperty
   property p_answer_in_pulse;
      s_answer_start |-> !host_oe_n && !$past(host_oe_n, 2);
   endproperty
   property p_one_answer_per_bit;
      s_answer_start |-> bit_seen_q;
   endproperty
   property p_answer_len;
      s_answer_end |-> dev_cnt_q >= DT_MIN && dev_cnt_q <= DT_MAX;
   endproperty
   property p_answer_never_long;
      dev_cnt_q <= DT_MAX;
   endproperty
   property p_host_low_width;
      $rose(host_oe_n) |-> host_cnt_q inside {T1_CYC, T2_CYC, T3_CYC};
   endproperty
   property p_released_after_reset;
      $rose(RST_B) |-> (dev_oe_n && host_oe_n) [*2];
   endproperty
   a_dev_pull_only: assert property (p_dev_pull_only)
      else $error("sensor drives the line high");
   a_host_pull_only: assert property (p_host_pull_only)
      else $error("master drives the line high");
   a_answer_in_pulse: assert property (p_answer_in_pulse)
      else $error("answer does not start inside the master pulse");
   a_one_answer_per_bit: assert property (p_one_answer_per_bit)
      else $error("second answer without a master bit");
   a_answer_len: assert property (p_answer_len)
      else $error("answer low time differs from delta time");
   a_answer_never_long: assert property (p_answer_never_long)
      else $error("answer low drive too long");
   a_host_low_width: assert property (p_host_low_width)
      else $error("master low width not a bit or pulse width");
   a_released_after_reset: assert property (p_released_after_reset)
      else $error("line driven right after reset");
   c_sensor_only_low: cover property (!line_lvl && host_oe_n);
endmodule // swl_properties
`default_nettype wire

// File: test_single_wire_pwm_bit_link.sv
// testbench joining the sensor end and the master end of the single-wire link
`timescale 1ns/10ps
`default_nettype none
module test_single_wire_pwm_bit_link
   import swl_pkg::*;
;
   // fastest legal period keeps the run short: 2 us, lows of 0.3T and 0.7T, 0.4 us pulse
   localparam int TC = 500;
   localparam int T1C = 150;
   localparam int T2C = 350;
   localparam int T3C = 100;
   localparam int DTC = TC - 2 * T1C;
   localparam int SMPC = DTC * SAMPLE_PCT / 100;
   localparam int LIM = 40000;
   logic ref_clk, rst_b, startup, cfg_en, start, rd_ready, wr_taken, busy, rd_valid, done;
   logic cmd_stb, wr_stb, echo_err, link_timeout, dq, hq;
   logic [WORD_W-1:0] rd_word, safety_word, cmd_in, wr_data, cmd_word, wr_word, rd_data, safe_out;
   logic [CNT_W-1:0] link_period;
   int n_errors, n_compared, n_dev, n_host, n_take, p0, f0;
   swl_if link_if();
   swl_dev #(.TRES_CYC(2000)) swl_dev_i (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(link_if),
      .STARTUP(startup), .LINK_CFG_EN(cfg_en), .RD_WORD(rd_word), .SAFETY_WORD(safety_word),
      .CMD_WORD(cmd_word), .CMD_STB(cmd_stb), .WR_WORD(wr_word), .WR_STB(wr_stb),
      .LINK_PERIOD(link_period), .LINK_TIMEOUT(link_timeout));
   swl_host #(.T_CYC(TC), .T1_CYC(T1C), .T2_CYC(T2C), .T3_CYC(T3C), .SMP_CYC(SMPC),
      .PAUSE_CYC(380)) swl_host_i (.REF_CLK(ref_clk), .RST_B(rst_b),
      .LINK(link_if), .START(start), .CMD_IN(cmd_in), .WR_DATA(wr_data), .WR_TAKEN(wr_taken),
      .BUSY(busy), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready),
      .SAFETY_OUT(safe_out), .DONE(done), .ECHO_ERR(echo_err));
   swl_properties #(.DT_MIN(DTC), .DT_MAX(DTC), .T1_CYC(T1C), .T2_CYC(T2C), .T3_CYC(T3C))
      swl_properties_i (.REF_CLK(ref_clk), .RST_B(rst_b),
      .dev_out(link_if.dev_out), .dev_oe_n(link_if.dev_oe_n), .host_out(link_if.host_out),
      .host_oe_n(link_if.host_oe_n), .line_lvl(link_if.line_lvl));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end
   // counts answer pulses and master falls on the wire, away from the launching edge
   always @(negedge ref_clk) begin
      if (dq === 1'h1 && link_if.dev_oe_n === 1'h0) n_dev++;
      if (hq === 1'h1 && link_if.host_oe_n === 1'h0) n_host++;
      if (wr_taken === 1'h1) n_take++;
      dq = link_if.dev_oe_n;
      hq = link_if.host_oe_n;
   end
   task automatic give_verdict();
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [15:0] c, input logic [15:0] w);
      @(posedge ref_clk);
      start <= 1'h1;
      cmd_in <= c;
      wr_data <= w;
      @(posedge ref_clk);
      start <= 1'h0;
   endtask
   // waits for a strobe or flag; a bound that runs out ends the run
   task automatic wait_on(input int which);
      logic hit;
      for (int i = 0; i < LIM; i++) begin
         @(negedge ref_clk);
         case (which)
            0: hit = cmd_stb;
            1: hit = wr_stb;
            2: hit = done;
            3: hit = rd_valid;
            default: hit = link_timeout;
         endcase
         if (hit === 1'h1) return;
      end
      n_errors++;
      $display("Error at %0t: wait %0d got 0x0 expected 0x1", $time, which);
      give_verdict();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      n_compared = 0;
      n_dev = 0;
      n_host = 0;
      n_take = 0;
      dq = 1'h1;
      hq = 1'h1;
      {rst_b, cfg_en, start, rd_ready} = 4'h0;
      startup = 1'h1;
      cmd_in = '0;
      wr_data = '0;
      rd_word = 16'hB46D;
      safety_word = 16'h9E17;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk(link_if.line_lvl, 32'h1);
      // write of one word; a second start while busy must be ignored
      p0 = n_dev;
      f0 = n_host;
      send(16'h5A31, 16'hC3A5);
      send(16'h1234, 16'hC3A5);
      wait_on(0);
      chk(cmd_word, 32'h5A31);
      chk(link_period >= TC - 1 && link_period <= TC + 1, 32'h1);
      wait_on(1);
      chk(wr_word, 32'hC3A5);
      wait_on(2);
      chk(safe_out, 32'h9E17);
      chk(echo_err, 32'h0);
      chk(busy, 32'h0);
      chk(n_dev - p0, $countones(48'h5A31C3A59E17));
      chk(n_host - f0, 32'd96);
      chk(n_take, 32'h1);
      // configured link replaces the start-up window for the rest of the run
      @(posedge ref_clk);
      startup <= 1'h0;
      cfg_en <= 1'h1;
      // read of three words with the reader stalled: buffer fills, line goes quiet
      send(16'h8003, 16'h0000);
      wait_on(3);
      @(posedge ref_clk);
      rd_word <= 16'h0F5E;
      wait_on(4);
      chk(rd_valid, 32'h1);
      chk(rd_data, 32'hB46D);
      @(posedge ref_clk);
      rd_ready <= 1'h1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(rd_data, 32'h0F5E);
      @(posedge ref_clk);
      rd_ready <= 1'h0;
      @(negedge ref_clk);
      chk(rd_valid, 32'h0);
      @(posedge ref_clk);
      rst_b <= 1'h0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk(link_if.dev_oe_n, 32'h1);
      chk(busy, 32'h0);
      give_verdict();
   end
endmodule // test_single_wire_pwm_bit_link
`default_nettype wire
